// [hw/host_bus_cfg.svh]
// constants of the host bus data-phase link
`ifndef HOST_BUS_CFG_SVH
`define HOST_BUS_CFG_SVH

`define HBD_DATA_W 64
`define HBD_GROUP_W 16
`define HBD_GROUPS 4
`define HBD_HALF_GROUP 8
`define HBD_BEATS_PER_XFER 4
`define HBD_BEAT_CYCLES 8
`define HBD_STB_FALL_CYCLE 4
`define HBD_GAP_CYCLES 8
`define HBD_FIFO_DEPTH 4
`define HBD_PIN_IDLE 1'b1

`endif

// [hw/host_bus_pkg.sv]
// types and line-coding functions shared by both ends
`include "host_bus_cfg.svh"

package host_bus_pkg;

    typedef logic [`HBD_GROUP_W-1:0] group_t;

    // pin levels, all active low as on the wires
    typedef struct packed {
        logic [`HBD_DATA_W-1:0] data_n;
        logic [`HBD_GROUPS-1:0] group_invert_flags_n;
        logic [`HBD_GROUPS-1:0] data_strobe_pos_n;
        logic [`HBD_GROUPS-1:0] data_strobe_neg_n;
        logic data_bus_occupied_n;
        logic data_valid_indication_n;
    } bus_pins_t;

    typedef enum logic [1:0] {S_IDLE, S_BEAT, S_GAP} tx_state_t;

    // returns {invert, pin levels} for one group
    function automatic logic [`HBD_GROUP_W:0] encode_group(input group_t data, input group_t last_pins);
        group_t plain;
        logic [4:0] changes;
        plain = ~data;
        changes = 5'h00;
        for (int i = 0; i < `HBD_GROUP_W; i++)
        begin
            changes = changes + 5'(plain[i] ^ last_pins[i]);
        end
        if (changes > 5'(`HBD_HALF_GROUP))
        begin
            return {1'b1, data};
        end
        return {1'b0, plain};
    endfunction

    // pins are sampled active high while the group is flagged inverted
    function automatic group_t decode_group(input group_t pins, input logic invert);
        return invert ? pins : ~pins;
    endfunction

endpackage

// [hw/host_bus_if.sv]
// pins of the host bus data phase between processor and bus agent
`timescale 1ns/1ps
`default_nettype none

interface host_bus_if;
    import host_bus_pkg::*;

    bus_pins_t cpu_out;
    bus_pins_t cpu_oe;
    bus_pins_t agent_out;
    bus_pins_t agent_oe;
    bus_pins_t pins;
    logic deferral_indication_n;

    // undriven lines float high
    assign pins = (cpu_out | ~cpu_oe) & (agent_out | ~agent_oe);

    modport cpu
    (
        output cpu_out,
        output cpu_oe,
        input pins,
        input deferral_indication_n
    );

    modport agent
    (
        output agent_out,
        output agent_oe,
        output deferral_indication_n,
        input pins
    );
endinterface

`default_nettype wire

// [hw/word_fifo.sv]
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_cfg.svh"

module word_fifo #(
    parameter int WIDTH = `HBD_DATA_W,
    parameter int DEPTH = `HBD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_size
        $error("word_fifo: depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

`default_nettype wire

// [hw/host_bus_cpu_end.sv]
// processor end: sends buffered words over the data phase with group inversion
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_cfg.svh"

module host_bus_cpu_end
    import host_bus_pkg::*;
#(
    parameter int BEAT_CYCLES = `HBD_BEAT_CYCLES,
    parameter int STB_FALL_CYCLE = `HBD_STB_FALL_CYCLE,
    parameter int GAP_CYCLES = `HBD_GAP_CYCLES,
    parameter int BEATS_PER_XFER = `HBD_BEATS_PER_XFER,
    parameter int FIFO_DEPTH = `HBD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`HBD_DATA_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic xfer_done,
    output logic xfer_deferred,
    output logic bus_occupied,
    host_bus_if.cpu bus
);
    localparam int CNT_W = $clog2((BEAT_CYCLES > GAP_CYCLES ? BEAT_CYCLES : GAP_CYCLES) + 1);
    localparam int IDX_W = $clog2(BEATS_PER_XFER + 1);

    if (BEAT_CYCLES < 8 || STB_FALL_CYCLE < 3 || STB_FALL_CYCLE > BEAT_CYCLES - 3)
    begin : g_bad_beat
        $error("host_bus_cpu_end: beat too short for a three-stage receiver");
    end
    if (GAP_CYCLES < 4 || BEATS_PER_XFER < 1)
    begin : g_bad_gap
        $error("host_bus_cpu_end: gap or burst length unusable");
    end

    // ------------------------------------------------------------
    // buffer in the data path
    // ------------------------------------------------------------
    logic [`HBD_DATA_W-1:0] fifo_data;
    logic fifo_valid;
    logic load;

    word_fifo #(
        .WIDTH(`HBD_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(load)
    );

    // ------------------------------------------------------------
    // pin synchronisers: occupied and deferral
    // ------------------------------------------------------------
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic busy_lvl_n;
    logic deferral_indication_lvl_n;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1 <= 2'h3;
            sync2 <= 2'h3;
            sync3 <= 2'h3;
        end
        else
        begin
            sync1 <= {bus.pins.data_bus_occupied_n, bus.deferral_indication_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_lvl_n <= 1'b1;
            deferral_indication_lvl_n <= 1'b1;
        end
        else
        begin
            if (sync2[1] == sync3[1])
                busy_lvl_n <= sync3[1];
            if (sync2[0] == sync3[0])
                deferral_indication_lvl_n <= sync3[0];
        end
    end

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    tx_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [IDX_W-1:0] beat_idx;
    logic last_cycle;
    logic bus_free;
    logic drive;

    assign last_cycle = cnt == CNT_W'(BEAT_CYCLES - 1);
    assign bus_free = busy_lvl_n && !drive;
    assign load = fifo_valid && ((state == S_IDLE && bus_free)
        || (state == S_BEAT && last_cycle && beat_idx != IDX_W'(BEATS_PER_XFER - 1)));
    assign bus_occupied = !busy_lvl_n;

    always_ff @(posedge clk)
    begin
        if (rst)
            state <= S_IDLE;
        else
        begin
            unique case (state)
                S_IDLE:
                begin
                    if (load)
                        state <= S_BEAT;
                end
                S_BEAT:
                begin
                    if (last_cycle && !load)
                        state <= S_GAP;
                end
                S_GAP:
                begin
                    if (cnt == CNT_W'(GAP_CYCLES - 1))
                        state <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || state == S_IDLE || load || (state == S_BEAT && last_cycle))
            cnt <= '0;
        else
            cnt <= cnt + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            beat_idx <= '0;
        else if (load && state == S_IDLE)
            beat_idx <= '0;
        else if (load)
            beat_idx <= beat_idx + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            drive <= 1'b0;
        else if (load && state == S_IDLE)
            drive <= 1'b1;
        else if (state == S_BEAT && last_cycle && !load)
            drive <= 1'b0;
    end

    // ------------------------------------------------------------
    // data encoding per group
    // ------------------------------------------------------------
    logic [`HBD_DATA_W-1:0] pin_data;
    logic [`HBD_GROUPS-1:0] invert;

    always_ff @(posedge clk)
    begin
        if (rst || (state == S_BEAT && last_cycle && !load))
        begin
            pin_data <= {`HBD_DATA_W{`HBD_PIN_IDLE}};
            invert <= '0;
        end
        else if (load)
        begin
            for (int g = 0; g < `HBD_GROUPS; g++)
            begin
                {invert[g], pin_data[g*`HBD_GROUP_W +: `HBD_GROUP_W]} <= encode_group(
                    fifo_data[g*`HBD_GROUP_W +: `HBD_GROUP_W], pin_data[g*`HBD_GROUP_W +: `HBD_GROUP_W]);
            end
        end
    end

    // ------------------------------------------------------------
    // strobes: positive on even beats, negative on odd
    // ------------------------------------------------------------
    logic stb_pos;
    logic stb_neg;

    always_ff @(posedge clk)
    begin
        if (rst || load || state != S_BEAT)
        begin
            stb_pos <= 1'b0;
            stb_neg <= 1'b0;
        end
        else if (cnt == CNT_W'(STB_FALL_CYCLE - 1))
        begin
            stb_pos <= !beat_idx[0];
            stb_neg <= beat_idx[0];
        end
    end

    // ------------------------------------------------------------
    // deferral capture
    // ------------------------------------------------------------
    logic deferral_indication_seen;

    always_ff @(posedge clk)
    begin
        if (rst || (load && state == S_IDLE))
            deferral_indication_seen <= 1'b0;
        else if (drive && !deferral_indication_lvl_n)
            deferral_indication_seen <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            xfer_done <= 1'b0;
            xfer_deferred <= 1'b0;
        end
        else
        begin
            xfer_done <= state == S_BEAT && last_cycle && !load;
            if (state == S_BEAT && last_cycle && !load)
                xfer_deferred <= deferral_indication_seen || !deferral_indication_lvl_n;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_comb
    begin
        bus.cpu_out.data_n = pin_data;
        bus.cpu_out.group_invert_flags_n = ~invert;
        bus.cpu_out.data_strobe_pos_n = {`HBD_GROUPS{!stb_pos}};
        bus.cpu_out.data_strobe_neg_n = {`HBD_GROUPS{!stb_neg}};
        bus.cpu_out.data_bus_occupied_n = !drive;
        bus.cpu_out.data_valid_indication_n = !drive;
        bus.cpu_oe = {$bits(bus_pins_t){drive}};
    end
endmodule

`default_nettype wire

// [hw/host_bus_agent_end.sv]
// bus agent end: receives and restores data beats, drives deferral
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_cfg.svh"

module host_bus_agent_end
    import host_bus_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic deferral_indication_req,
    output logic [`HBD_DATA_W-1:0] rx_data,
    output logic rx_valid,
    output logic bus_occupied,
    host_bus_if.agent bus
);
    // ------------------------------------------------------------
    // three-stage pin synchroniser with agreement filter
    // ------------------------------------------------------------
    bus_pins_t sync1;
    bus_pins_t sync2;
    bus_pins_t sync3;
    bus_pins_t lvl;
    bus_pins_t lvl_prev;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1 <= '1;
            sync2 <= '1;
            sync3 <= '1;
            lvl <= '1;
            lvl_prev <= '1;
        end
        else
        begin
            sync1 <= bus.pins;
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= ((sync2 ^ sync3) & lvl) | (~(sync2 ^ sync3) & sync3);
            lvl_prev <= lvl;
        end
    end

    // ------------------------------------------------------------
    // per-group capture on falling strobes
    // ------------------------------------------------------------
    logic [`HBD_GROUPS-1:0] strobe_fall;

    for (genvar g = 0; g < `HBD_GROUPS; g++)
    begin : grp
        assign strobe_fall[g] = !lvl.data_valid_indication_n
            && ((lvl_prev.data_strobe_pos_n[g] && !lvl.data_strobe_pos_n[g])
            || (lvl_prev.data_strobe_neg_n[g] && !lvl.data_strobe_neg_n[g]));

        always_ff @(posedge clk)
        begin
            if (rst)
                rx_data[g*`HBD_GROUP_W +: `HBD_GROUP_W] <= '0;
            else if (strobe_fall[g])
                rx_data[g*`HBD_GROUP_W +: `HBD_GROUP_W] <= decode_group(
                    lvl.data_n[g*`HBD_GROUP_W +: `HBD_GROUP_W], !lvl.group_invert_flags_n[g]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rx_valid <= 1'b0;
        else
            rx_valid <= strobe_fall[0];
    end

    // ------------------------------------------------------------
    // occupancy and deferral
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            bus_occupied <= 1'b0;
        else
            bus_occupied <= !lvl.data_bus_occupied_n;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            bus.deferral_indication_n <= 1'b1;
        else
            bus.deferral_indication_n <= !deferral_indication_req;
    end

    // this end never drives the data-phase lines
    assign bus.agent_out = '1;
    assign bus.agent_oe = '0;
endmodule

`default_nettype wire

// [verif/host_bus_asserts.sv]
// concurrent checks on the host bus data-phase pins
`timescale 1ns/1ps
`default_nettype none

module host_bus_asserts
    import host_bus_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire bus_pins_t cpu_oe,
    input wire bus_pins_t pins
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic drv;
    logic stb;
    assign drv = cpu_oe.data_bus_occupied_n;
    assign stb = !pins.data_strobe_pos_n[0] || !pins.data_strobe_neg_n[0];

    // no group moves more than half its lines
    function automatic logic few_moves(input logic [63:0] a, input logic [63:0] b);
        few_moves = 1'b1;
        for (int g = 0; g < 4; g++)
        begin
            if ($countones(a[16*g+:16] ^ b[16*g+:16]) > 8)
                few_moves = 1'b0;
        end
    endfunction

    // flagged group only where plain levels would move over half
    function automatic logic flags_fit(input logic [63:0] a, input logic [63:0] b, input logic [3:0] f_n);
        flags_fit = 1'b1;
        for (int g = 0; g < 4; g++)
        begin
            if (!f_n[g] && $countones(~a[16*g+:16] ^ b[16*g+:16]) <= 8)
                flags_fit = 1'b0;
        end
    endfunction

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pairs_match: assert property (drv |-> pins.data_strobe_pos_n inside {4'h0, 4'hf})
        else $error("strobe pairs differ");
    a_busy_while_drive: assert property (drv |-> !pins.data_bus_occupied_n)
        else $error("occupied not asserted while driving");
    a_valid_while_drive: assert property (drv |-> !pins.data_valid_indication_n)
        else $error("data valid not asserted while driving");
    a_strobe_owned: assert property (stb |-> drv && !(!pins.data_strobe_pos_n[0] && !pins.data_strobe_neg_n[0]))
        else $error("strobe outside drive or both strobes low");
    a_data_held: assert property (stb && $past(stb) |-> $stable(pins.data_n) && $stable(pins.group_invert_flags_n))
        else $error("data moved while strobe low");
    a_strobe_width: assert property ($fell(pins.data_strobe_pos_n[0]) |->
        !pins.data_strobe_pos_n[0] [*3] ##[1:2] pins.data_strobe_pos_n[0])
        else $error("strobe low time wrong");
    a_move_limit: assert property (drv |-> few_moves(pins.data_n, $past(pins.data_n)))
        else $error("group moved over half its lines");
    a_flag_exact: assert property (drv |->
        flags_fit(pins.data_n, $past(pins.data_n), pins.group_invert_flags_n))
        else $error("inversion flag without need");
    a_release_gap: assert property ($fell(drv) |-> !drv [*8])
        else $error("bus retaken too soon");
    a_burst_length: assert property ($rose(drv) |-> drv [*8] ##[1:25] !drv)
        else $error("burst length out of range");
endmodule

`default_nettype wire

// [verif/host_bus_data_inversion_busy_tb_top.sv]
// self-checking bench joining processor end and bus agent end
`timescale 1ns/1ps
`default_nettype none

module host_bus_data_inversion_busy_tb_top;
    logic clk;
    logic rst = 1'b1;
    logic [63:0] tx_data = 64'h0;
    logic tx_valid = 1'b0;
    logic tx_ready;
    logic xfer_done;
    logic xfer_deferred;
    logic cpu_busy;
    logic deferral_indication_req = 1'b0;
    logic [63:0] rx_data;
    logic rx_valid;
    logic agent_busy;
    logic stb;
    logic stb_d = 1'b0;
    logic [63:0] wire_last = '1;
    logic [63:0] rx_q[$];
    logic [63:0] exp_q[$];
    logic [63:0] wire_q[$];
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int refusals = 0;
    int dones = 0;

    host_bus_if bus();
    host_bus_cpu_end i_host_bus_cpu_end (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .xfer_done(xfer_done), .xfer_deferred(xfer_deferred),
        .bus_occupied(cpu_busy), .bus(bus));
    host_bus_agent_end i_host_bus_agent_end (.clk(clk), .rst(rst), .deferral_indication_req(deferral_indication_req), .rx_data(rx_data),
        .rx_valid(rx_valid), .bus_occupied(agent_busy), .bus(bus));
    host_bus_asserts i_host_bus_asserts (.clk(clk), .rst(rst), .cpu_oe(bus.cpu_oe), .pins(bus.pins));

    assign stb = (bus.pins.data_strobe_pos_n[0] & bus.pins.data_strobe_neg_n[0]) === 1'b0;

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_word(what, 64'(exp), 64'(got));
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // wire model: expected levels per group against last driven levels
    task automatic check_beat(input logic [63:0] w);
        logic [63:0] p;
        logic [3:0] f;
        for (int g = 0; g < 4; g++)
        begin
            p[16*g+:16] = ~w[16*g+:16];
            f[g] = 1'b1;
            if ($countones(p[16*g+:16] ^ wire_last[16*g+:16]) > 8)
            begin
                p[16*g+:16] = w[16*g+:16];
                f[g] = 1'b0;
            end
        end
        wire_last = p;
        check_word("wire data", p, bus.pins.data_n);
        check_word("wire flags", 64'(f), 64'(bus.pins.group_invert_flags_n));
        check_bit("wire valid", 1'b0, bus.pins.data_valid_indication_n);
        check_bit("cpu busy", 1'b1, cpu_busy);
    endtask

    // ------------------------------------------------------------
    // monitors and timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            report_and_stop();
        end
        if (rx_valid === 1'b1)
        begin
            rx_q.push_back(rx_data);
            check_bit("agent busy", 1'b1, agent_busy);
        end
        if (xfer_done === 1'b1)
            dones++;
        if (tx_valid === 1'b1 && tx_ready !== 1'b1)
            refusals++;
        stb_d <= stb;
        if (stb && !stb_d)
            check_beat(wire_q.pop_front());
        if (bus.pins.data_bus_occupied_n === 1'b1)
            wire_last = '1;
    end

    // ------------------------------------------------------------
    // stream tasks and tests
    // ------------------------------------------------------------
    task automatic send(input logic [63:0] ws[$]);
        foreach (ws[i])
        begin
            tx_data <= ws[i];
            tx_valid <= 1'b1;
            @(posedge clk);
            while (tx_ready !== 1'b1)
                @(posedge clk);
            exp_q.push_back(ws[i]);
            wire_q.push_back(ws[i]);
        end
        tx_valid <= 1'b0;
    endtask

    task automatic drain(input string name, input int bursts);
        repeat (400)
        begin
            @(posedge clk);
            if (rx_q.size() == exp_q.size() && cpu_busy === 1'b0 && agent_busy === 1'b0)
                break;
        end
        repeat (12) @(posedge clk);
        check_word("word count", 64'(exp_q.size()), 64'(rx_q.size()));
        foreach (exp_q[i])
            check_word("received word", exp_q[i], rx_q[i]);
        check_bit("cpu busy after", 1'b0, cpu_busy);
        check_bit("agent busy after", 1'b0, agent_busy);
        check_word("burst count", 64'(bursts), 64'(dones));
        dones = 0;
        rx_q.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        send('{64'h0, 64'h0000_01ff_00ff_ffff, 64'hffff_fe00_ff00_0000, 64'h5555_aaaa_0f0f_f0f0});
        drain("inversion", 1);
        send('{64'h1, 64'h2, 64'h3, 64'h4, 64'h5, 64'h6});
        drain("fifo fill", 2);
        check_bit("refusal seen", 1'b1, refusals > 0);
        deferral_indication_req <= 1'b1;
        repeat (2) @(posedge clk);
        check_bit("deferral line", 1'b0, bus.deferral_indication_n);
        send('{64'hdead_beef_0123_4567, 64'h0, 64'hffff_0000_ffff_0000});
        drain("deferred", 1);
        check_bit("deferred flag", 1'b1, xfer_deferred);
        deferral_indication_req <= 1'b0;
        repeat (12) @(posedge clk);
        send('{64'h8000_0001_7fff_fffe});
        drain("in order", 1);
        check_bit("deferred clear", 1'b0, xfer_deferred);
        report_and_stop();
    end
endmodule

`default_nettype wire
